// ### dv/dma_cfg_checker.sv
// Concurrent checks on the ports of the DMA data configuration block.
`default_nettype none
module dma_cfg_checker
    import dma_cfg_pkg::*;
(
    // Clock, reset and register port
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic [4:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    // Engine and bus side
    input wire logic [4:0]  i_fifo_bytes,
    input wire logic        i_rx_dir,
    input wire logic        i_xfer_done,
    input wire logic [15:0] i_dma_addr,
    input wire logic [15:0] i_dma_data,
    input wire logic        i_remove_cmd,
    input wire logic        o_bus_request_out,
    input wire logic [31:0] o_sys_addr,
    input wire logic [15:0] o_ad_data,
    input wire logic        o_word_transfer_mode,
    input wire logic        o_long_address_mode,
    input wire logic        o_loopback_select_n,
    input wire logic        o_auto_remove_start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0]  cfg;
    logic [6:0]  lat;
    logic [15:0] rs;
    logic [3:0]  cnt;

    function automatic logic [4:0] thr(input logic [1:0] c);
        return c == 2'h3 ? 5'h0c : 5'h02 << c;
    endfunction

    // The burst figure is latched while idle, so a write during a burst does not move it.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg <= 7'h04;
            lat <= 7'h04;
            rs  <= 16'h0000;
            cnt <= 4'h0;
        end else begin
            if (i_reg_wr && i_reg_addr == OFS_DATA_PATH_CONFIG) cfg <= i_reg_wdata[6:0];
            if (i_reg_wr && i_reg_addr == OFS_REMOTE_START_LO) rs[7:0] <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == OFS_REMOTE_START_HI) rs[15:8] <= i_reg_wdata;
            if (!o_bus_request_out) lat <= cfg;
            cnt <= o_bus_request_out ? cnt + 4'(i_xfer_done) : 4'h0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_cfg_wr;
        i_reg_wr && i_reg_addr == OFS_DATA_PATH_CONFIG;
    endsequence
    sequence s_live;
        !$past(i_sys_rst);
    endsequence

    a_reset_long_addr: assert property ($fell(i_sys_rst) |-> o_long_address_mode
        && !o_word_transfer_mode && !o_bus_request_out) else $error("reset values wrong");
    a_word_mode_set: assert property (s_cfg_wr |-> ##2
        o_word_transfer_mode == $past(i_reg_wdata[0], 2)) else $error("word mode wrong");
    a_long_addr_set: assert property (s_cfg_wr |-> ##2
        o_long_address_mode == $past(i_reg_wdata[2], 2)) else $error("address mode wrong");
    a_loopback_sel_set: assert property (s_cfg_wr |-> ##2
        o_loopback_select_n == $past(i_reg_wdata[3], 2)) else $error("loopback wrong");
    a_sys_addr_map: assert property (s_live |-> o_sys_addr ==
        {$past(cfg[2]) ? $past(rs) : 16'h0000, $past(i_dma_addr[15:1]),
         $past(i_dma_addr[0]) & ~$past(cfg[0])}) else $error("address out wrong");
    a_byte_lane_map: assert property (s_live |-> o_ad_data ==
        (($past(cfg[0]) && $past(cfg[1])) ? {$past(i_dma_data[7:0]), $past(i_dma_data[15:8])}
        : $past(i_dma_data))) else $error("byte lanes wrong");
    a_remove_start: assert property (s_live |-> o_auto_remove_start ==
        ($past(i_remove_cmd) && $past(cfg[4]))) else $error("auto remove wrong");
    a_request_level: assert property ($rose(o_bus_request_out) |->
        ($past(i_rx_dir) ? $past(i_fifo_bytes) >= thr($past(cfg[6:5]))
        : $past(i_fifo_bytes) <= 5'h10 - thr($past(cfg[6:5])))) else $error("request level");
    a_burst_length: assert property ($fell(o_bus_request_out) |->
        cnt == 4'(lat[0] ? thr(lat[6:5]) >> 1 : thr(lat[6:5]))) else $error("burst length");
    a_config_readback: assert property (i_reg_rd && i_reg_addr == OFS_CONFIG_READBACK
        |=> o_reg_rdata == {1'b0, $past(cfg)}) else $error("readback wrong");
endmodule // dma_cfg_checker

bind dma_data_configuration dma_cfg_checker u_checker (
    .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_fifo_bytes, .i_rx_dir, .i_xfer_done, .i_dma_addr, .i_dma_data, .i_remove_cmd,
    .o_bus_request_out, .o_sys_addr, .o_ad_data, .o_word_transfer_mode,
    .o_long_address_mode, .o_loopback_select_n, .o_auto_remove_start
);
`default_nettype wire

// ### dv/dma_data_configuration_tb.sv
// Self-checking bench for the DMA data configuration block.
`default_nettype none
module dma_data_configuration_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_cfg_pkg::*;

    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic        i_rx_dir = 1'b1, i_remote_cycle = 1'b0, i_remove_cmd = 1'b0, i_slow = 1'b0;
    logic [4:0]  i_reg_addr = 5'h00, i_fifo_bytes = 5'h00;
    logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata, c, d;
    logic [15:0] i_dma_addr = 16'h0000, i_dma_data = 16'h0000, o_ad_data, rs, a, dd;
    logic [31:0] o_sys_addr;
    logic [4:0]  t;
    wire logic   i_bus_ack, i_xfer_done;
    logic        o_bus_request_out, o_word_transfer_mode, o_long_address_mode;
    logic        o_loopback_select_n, o_auto_remove_start;
    logic [7:0]  corner [4] = '{8'hff, 8'h00, 8'h82, 8'h03};
    integer      seed = 32'he122;
    int          failures = 0, comparisons = 0, cnt;

    always #25 i_clk = ~i_clk;

    dma_data_configuration DUT (
        .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
        .i_fifo_bytes, .i_rx_dir, .i_bus_ack, .i_xfer_done, .i_remote_cycle, .i_dma_addr,
        .i_dma_data, .i_remove_cmd, .o_bus_request_out, .o_sys_addr, .o_ad_data,
        .o_word_transfer_mode, .o_long_address_mode, .o_loopback_select_n,
        .o_auto_remove_start
    );
    sys_bus_model bus (.i_clk, .i_sys_rst, .i_request(o_bus_request_out), .i_slow,
        .o_ack(i_bus_ack), .o_done(i_xfer_done));

    function automatic logic [4:0] thr(input logic [1:0] k);
        return k == 2'h3 ? 5'h0c : 5'h02 << k;
    endfunction

    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Each strobe is followed by a quiet cycle so no signal is assigned twice in one step.
    task automatic wr(input logic [4:0] ad, input logic [7:0] v);
        i_reg_addr  <= ad;
        i_reg_wdata <= v;
        i_reg_wr    <= 1'b1;
        tick;
        i_reg_wr <= 1'b0;
        tick;
    endtask

    task automatic rd(input logic [4:0] ad, output logic [7:0] v);
        i_reg_addr <= ad;
        i_reg_rd   <= 1'b1;
        tick;
        // Read data stand only in the cycle after the strobe, so take them now.
        v = o_reg_rdata;
        i_reg_rd <= 1'b0;
        tick;
    endtask

    task automatic tally_and_finish;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        tick;
        chk(32'(o_long_address_mode), 32'h1);
        rd(OFS_CONFIG_READBACK, d);
        chk(32'(d), 32'h04);
        rd(5'h1f, d);
        chk(32'(d), 32'h0);
        rd(OFS_DATA_PATH_CONFIG, d);
        chk(32'(d), 32'h0);
        // Receive direction with an empty FIFO keeps the bus quiet while modes are swept.
        for (int n = 0; n < 24; n++) begin
            c  = n < 4 ? corner[n] : 8'($random(seed));
            rs = 16'($random(seed));
            a  = 16'($random(seed));
            dd = 16'($random(seed));
            wr(OFS_REMOTE_START_LO, rs[7:0]);
            wr(OFS_REMOTE_START_HI, rs[15:8]);
            wr(OFS_DATA_PATH_CONFIG, c);
            i_dma_addr     <= a;
            i_dma_data     <= dd;
            i_remote_cycle <= 1'($random(seed));
            tick;
            chk(32'(o_word_transfer_mode), 32'(c[0]));
            chk(32'(o_long_address_mode), 32'(c[2]));
            chk(32'(o_loopback_select_n), 32'(c[3]));
            chk(o_sys_addr, {c[2] ? rs : 16'h0000, a[15:1], a[0] & ~c[0]});
            chk(32'(o_ad_data), 32'(c[0] & c[1] ? {dd[7:0], dd[15:8]} : dd));
            rd(OFS_CONFIG_READBACK, d);
            chk(32'(d), 32'(c[6:0]));
        end
        rd(OFS_REMOTE_START_LO, d);
        chk(32'(d), 32'(rs[7:0]));
        rd(OFS_REMOTE_START_HI, d);
        chk(32'(d), 32'(rs[15:8]));
        rd(OFS_ENGINE_STATUS, d);
        chk(32'(d), {25'h0, i_remote_cycle, 6'h00});
        // A second reset in mid-run must bring the power-up mode back.
        i_sys_rst <= 1'b1;
        repeat (2) tick;
        i_sys_rst <= 1'b0;
        tick;
        chk(32'(o_long_address_mode), 32'h1);
        rd(OFS_CONFIG_READBACK, d);
        chk(32'(d), 32'(CONFIG_RESET));
        for (int ar = 0; ar < 2; ar++) begin
            wr(OFS_DATA_PATH_CONFIG, {3'h0, 1'(ar), 4'h9});
            i_remove_cmd <= 1'b1;
            tick;
            i_remove_cmd <= 1'b0;
            chk(32'(o_auto_remove_start), 32'(ar));
            tick;
            chk(32'(o_auto_remove_start), 32'h0);
        end
        // Code, width and direction in every combination, the bus fast and slow.
        for (int k = 0; k < 16; k++) begin
            i_rx_dir     <= k[3];
            i_fifo_bytes <= k[3] ? 5'h00 : 5'h10;
            i_slow       <= k[0] ^ k[3];
            c = {1'b0, 2'(k), 4'he, k[2]};
            t = thr(2'(k));
            wr(OFS_DATA_PATH_CONFIG, c);
            i_fifo_bytes <= k[3] ? t - 5'h01 : 5'h11 - t;
            repeat (4) tick;
            chk(32'(o_bus_request_out), 32'h0);
            i_fifo_bytes <= k[3] ? t : 5'h10 - t;
            tick;
            tick;
            chk(32'(o_bus_request_out), 32'h1);
            i_fifo_bytes <= k[3] ? 5'h00 : 5'h10;
            cnt = 0;
            for (int w = 0; w < 40 && o_bus_request_out === 1'b1; w++) begin
                if (i_xfer_done === 1'b1) cnt++;
                tick;
            end
            chk(32'(cnt), 32'(k[2] ? t >> 1 : t));
        end
        tally_and_finish;
    end
endmodule // dma_data_configuration_tb
`default_nettype wire

// ### dv/sys_bus_model.sv
// Behavioural system bus that grants the DMA and runs its bursts.
`default_nettype none
module sys_bus_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Request side
    input  wire logic i_request,
    input  wire logic i_slow,
    output logic      o_ack,
    output logic      o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;

    // A slow bus grants four cycles late and moves data only every other cycle.
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst || !i_request) begin
            o_ack    <= 1'b0;
            o_done   <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (!o_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
            o_ack    <= !i_slow || wait_cnt == 2'h3;
        end else begin
            o_done <= i_slow ? !o_done : 1'b1;
        end
    end
endmodule // sys_bus_model
`default_nettype wire

// ### rtl/byte_lane_steer.sv
// Byte lane steering for the multiplexed address/data bus.
`default_nettype none
module byte_lane_steer (
    // Control
    input  wire logic        i_swap,
    // Data
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data
);
    assign o_data = i_swap ? {i_data[7:0], i_data[15:8]} : i_data;
endmodule // byte_lane_steer
`default_nettype wire

// ### rtl/dma_cfg_pkg.sv
// Package of offsets, field positions, reset values and FIFO figures for the DMA configuration.
`default_nettype none
package dma_cfg_pkg;
    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [4:0] OFS_REMOTE_START_LO = 5'h08;
    localparam logic [4:0] OFS_REMOTE_START_HI = 5'h09;
    localparam logic [4:0] OFS_DATA_PATH_CONFIG = 5'h0e;
    localparam logic [4:0] OFS_ENGINE_STATUS = 5'h10;
    localparam logic [4:0] OFS_CONFIG_READBACK = 5'h11;

    // -----------------------------------------------------------------
    // Field positions of data_path_config
    // -----------------------------------------------------------------
    localparam int BIT_WORD_TRANSFER = 0;
    localparam int BIT_BYTE_SWAP = 1;
    localparam int BIT_LONG_ADDRESS = 2;
    localparam int BIT_LOOPBACK_N = 3;
    localparam int BIT_AUTO_REMOTE = 4;
    localparam int BIT_FIFO_CODE_LO = 5;
    localparam int BIT_FIFO_CODE_HI = 6;
    localparam int CONFIG_USED_BITS = 7;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [6:0] CONFIG_RESET = 7'h04;
    localparam logic [15:0] REMOTE_START_RESET = 16'h0000;

    // -----------------------------------------------------------------
    // FIFO figures, in bytes
    // -----------------------------------------------------------------
    localparam logic [4:0] FIFO_DEPTH_BYTES = 5'h10;
    localparam logic [4:0] RX_THR_CODE0 = 5'h02;
    localparam logic [4:0] RX_THR_CODE1 = 5'h04;
    localparam logic [4:0] RX_THR_CODE2 = 5'h08;
    localparam logic [4:0] RX_THR_CODE3 = 5'h0c;

    // -----------------------------------------------------------------
    // Bus request states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_REQUEST = 2'b01,
        ST_BURST   = 2'b11,
        ST_RELEASE = 2'b10
    } bus_state_type;
endpackage
`default_nettype wire

// ### rtl/dma_data_configuration.sv
// Data path configuration and bus request control of the dual DMA channels.
//
// Behaviour
// - Reset sets long address mode high.
// - Bit 0 picks byte (0) or word (1) transfers for both DMA channels.
// - Word mode addresses up to 32k words with address bit zero low.
// - Bit 1 low puts MS byte on AD15-AD8; high swaps lanes.
// - Byte order bit is ignored while byte transfers are selected.
// - Bit 2 picks dual 16-bit (0) or single 32-bit (1) addressing.
// - Long address mode drives remote start address on A16-A31.
// - Bit 3 low selects loopback; transmit config must also be set.
// - Bit 4 high runs auto-remove via remote DMA; low ignores it.
// - Bits 5 and 6 set the receive level that raises bus request.
// - The threshold also sets the burst length.
// - Transmit threshold is 16 bytes minus the receive threshold.
//
// Strobed register access was decided locally.
`default_nettype none
module dma_data_configuration
    import dma_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Register port
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // FIFO and DMA engine side
    input  wire logic [4:0]  i_fifo_bytes,
    input  wire logic        i_rx_dir,
    input  wire logic        i_bus_ack,
    input  wire logic        i_xfer_done,
    input  wire logic        i_remote_cycle,
    input  wire logic [15:0] i_dma_addr,
    input  wire logic [15:0] i_dma_data,
    input  wire logic        i_remove_cmd,
    // System bus side
    output logic             o_bus_request_out,
    output logic      [31:0] o_sys_addr,
    output logic      [15:0] o_ad_data,
    // Mode outputs
    output logic             o_word_transfer_mode,
    output logic             o_long_address_mode,
    output logic             o_loopback_select_n,
    output logic             o_auto_remove_start
);
    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic [6:0]  data_path_config;
    logic [6:0]  next_data_path_config;
    logic [15:0] remote_start_addr;
    logic [15:0] next_remote_start_addr;

    // Writes land one cycle after the strobe; the mode outputs follow a
    // cycle later still, so software sees the new width two cycles on.

    always_comb begin
        next_data_path_config = data_path_config;
        next_remote_start_addr = remote_start_addr;
        if (i_reg_wr) begin
            case (i_reg_addr)
                OFS_DATA_PATH_CONFIG: begin
                    // The top bit has no function and is dropped here.
                    next_data_path_config = i_reg_wdata[CONFIG_USED_BITS-1:0];
                end
                OFS_REMOTE_START_LO: begin
                    next_remote_start_addr[7:0] = i_reg_wdata;
                end
                OFS_REMOTE_START_HI: begin
                    next_remote_start_addr[15:8] = i_reg_wdata;
                end
                default: begin
                    next_data_path_config = data_path_config;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_path_config <= CONFIG_RESET;
            remote_start_addr <= REMOTE_START_RESET;
        end else begin
            data_path_config <= next_data_path_config;
            remote_start_addr <= next_remote_start_addr;
        end
    end

    // -----------------------------------------------------------------
    // Field decode
    // -----------------------------------------------------------------
    logic       word_transfer_mode;
    logic       byte_swap_order;
    logic       long_address_mode;
    logic       loopback_select_n;
    logic       auto_remote_init;
    logic [1:0] fifo_level_code;
    logic       lane_swap;

    assign word_transfer_mode = data_path_config[BIT_WORD_TRANSFER];
    assign byte_swap_order = data_path_config[BIT_BYTE_SWAP];
    assign long_address_mode = data_path_config[BIT_LONG_ADDRESS];
    assign loopback_select_n = data_path_config[BIT_LOOPBACK_N];
    assign auto_remote_init = data_path_config[BIT_AUTO_REMOTE];
    // Auto-remove with swapped lanes is a software restriction; the block
    // does not police it, so a misuse drains the ring with crossed bytes.
    assign fifo_level_code = {data_path_config[BIT_FIFO_CODE_HI],
                              data_path_config[BIT_FIFO_CODE_LO]};
    // Lane order only matters when both bytes of a word travel together.
    assign lane_swap = word_transfer_mode & byte_swap_order;

    // -----------------------------------------------------------------
    // Threshold decode and lane steering
    // -----------------------------------------------------------------
    logic [4:0]  rx_thr_bytes;
    logic [4:0]  tx_thr_bytes;
    logic [4:0]  burst_units;
    logic [15:0] steered_data;

    fifo_threshold_map u_thr_map (
        .i_code         (fifo_level_code),
        .i_word_mode    (word_transfer_mode),
        .o_rx_thr_bytes (rx_thr_bytes),
        .o_tx_thr_bytes (tx_thr_bytes),
        .o_burst_units  (burst_units)
    );

    byte_lane_steer u_lane (
        .i_swap (lane_swap),
        .i_data (i_dma_data),
        .o_data (steered_data)
    );

    // -----------------------------------------------------------------
    // Bus request and burst control
    // -----------------------------------------------------------------
    bus_state_type bus_state;
    bus_state_type next_bus_state;
    logic [4:0]    burst_count;
    logic [4:0]    next_burst_count;
    logic [4:0]    burst_target;
    logic [4:0]    next_burst_target;
    logic          level_reached;

    // The transmit compare is inclusive: a FIFO holding exactly the
    // complement of the receive figure already has room for one burst.
    // Receive fills from the network; transmit requests once the local
    // DMA has room left for a whole burst.
    always_comb begin
        if (i_rx_dir) begin
            level_reached = (i_fifo_bytes >= rx_thr_bytes);
        end else begin
            level_reached = (i_fifo_bytes <= tx_thr_bytes);
        end
    end

    always_comb begin
        next_bus_state = bus_state;
        next_burst_count = burst_count;
        next_burst_target = burst_target;
        case (bus_state)
            ST_IDLE: begin
                next_burst_count = 5'h00;
                if (level_reached) begin
                    next_bus_state = ST_REQUEST;
                    // Burst length is frozen so a mid-burst write cannot cut it.
                    next_burst_target = burst_units;
                end
            end
            ST_REQUEST: begin
                if (i_bus_ack) begin
                    next_bus_state = ST_BURST;
                end
            end
            ST_BURST: begin
                if (i_xfer_done) begin
                    next_burst_count = burst_count + 5'h01;
                    if (burst_count + 5'h01 >= burst_target) begin
                        next_bus_state = ST_RELEASE;
                    end
                end
            end
            ST_RELEASE: begin
                // One quiet cycle lets the bus owner see the request drop
                // before the FIFO level is judged again.
                next_bus_state = ST_IDLE;
                next_burst_count = 5'h00;
            end
            default: begin
                next_bus_state = ST_IDLE;
                next_burst_count = 5'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_state <= ST_IDLE;
            burst_count <= 5'h00;
            burst_target <= 5'h00;
        end else begin
            bus_state <= next_bus_state;
            burst_count <= next_burst_count;
            burst_target <= next_burst_target;
        end
    end

    // -----------------------------------------------------------------
    // Bus outputs
    // -----------------------------------------------------------------
    logic        next_bus_request;
    logic [31:0] next_sys_addr;
    logic [15:0] next_ad_data;
    logic        next_auto_remove_start;

    always_comb begin
        next_bus_request = (next_bus_state == ST_REQUEST) ||
                           (next_bus_state == ST_BURST);
        next_sys_addr[15:0] = i_dma_addr;
        if (word_transfer_mode) begin
            // Byte address bit zero stays low, leaving 32k word addresses.
            next_sys_addr[0] = 1'b0;
        end
        if (long_address_mode) begin
            next_sys_addr[31:16] = remote_start_addr;
        end else begin
            next_sys_addr[31:16] = 16'h0000;
        end
        next_ad_data = steered_data;
        // Without the auto flag the command is dropped and software drains
        // the ring itself.
        next_auto_remove_start = i_remove_cmd & auto_remote_init;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_bus_request_out <= 1'b0;
            o_sys_addr <= 32'h00000000;
            o_ad_data <= 16'h0000;
            o_auto_remove_start <= 1'b0;
        end else begin
            o_bus_request_out <= next_bus_request;
            o_sys_addr <= next_sys_addr;
            o_ad_data <= next_ad_data;
            o_auto_remove_start <= next_auto_remove_start;
        end
    end

    // -----------------------------------------------------------------
    // Mode outputs
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_word_transfer_mode <= CONFIG_RESET[BIT_WORD_TRANSFER];
            o_long_address_mode <= CONFIG_RESET[BIT_LONG_ADDRESS];
            o_loopback_select_n <= CONFIG_RESET[BIT_LOOPBACK_N];
        end else begin
            o_word_transfer_mode <= word_transfer_mode;
            o_long_address_mode <= long_address_mode;
            o_loopback_select_n <= loopback_select_n;
        end
    end

    // -----------------------------------------------------------------
    // Register read
    // -----------------------------------------------------------------
    logic [7:0] next_reg_rdata;
    logic [7:0] engine_status;

    // Read data stand for one cycle only and return to zero, so a late
    // sample by the host reads zero rather than stale contents.
    // The remote cycle flag tells software which channel holds the bus.
    assign engine_status = {1'b0, i_remote_cycle, burst_count[3:0],
                            bus_state == ST_BURST, o_bus_request_out};

    always_comb begin
        next_reg_rdata = 8'h00;
        if (i_reg_rd) begin
            case (i_reg_addr)
                OFS_REMOTE_START_LO: next_reg_rdata = remote_start_addr[7:0];
                OFS_REMOTE_START_HI: next_reg_rdata = remote_start_addr[15:8];
                OFS_ENGINE_STATUS:   next_reg_rdata = engine_status;
                OFS_CONFIG_READBACK: next_reg_rdata = {1'b0, data_path_config};
                // The configuration offset itself is write only.
                default:             next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= next_reg_rdata;
        end
    end
endmodule // dma_data_configuration
`default_nettype wire

// ### rtl/fifo_threshold_map.sv
// Decoder from the FIFO level code to request thresholds and burst length.
`default_nettype none
module fifo_threshold_map
    import dma_cfg_pkg::*;
(
    // Configuration
    input  wire logic [1:0] i_code,
    input  wire logic       i_word_mode,
    // Decoded figures
    output logic      [4:0] o_rx_thr_bytes,
    output logic      [4:0] o_tx_thr_bytes,
    output logic      [4:0] o_burst_units
);
    always_comb begin
        case (i_code)
            2'b00:   o_rx_thr_bytes = RX_THR_CODE0;
            2'b01:   o_rx_thr_bytes = RX_THR_CODE1;
            2'b10:   o_rx_thr_bytes = RX_THR_CODE2;
            default: o_rx_thr_bytes = RX_THR_CODE3;
        endcase
    end

    // A word is two bytes, so the byte figure serves both widths.
    assign o_tx_thr_bytes = FIFO_DEPTH_BYTES - o_rx_thr_bytes;
    // Burst length counts bus transfers, which are words in word mode.
    assign o_burst_units = i_word_mode ? {1'b0, o_rx_thr_bytes[4:1]}
                                       : o_rx_thr_bytes;
endmodule // fifo_threshold_map
`default_nettype wire
